// [design/fsq_pkg.sv]
/*
 * Shared constants for the dual/quad read serial flash link: opcodes,
 * dummy cycle table, register map of the host controller, link timing.
 * Assumes both ends are compiled after this package.
 */
package fsq_pkg;
	// ************************************************
	// Opcodes
	// ************************************************
	localparam logic [7:0] OP_DUAL_IO_READ  = 8'hbb;
	localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
	localparam logic [7:0] OP_ENTER_WIDE    = 8'hb7;
	localparam logic [7:0] OP_EXIT_WIDE     = 8'he9;
	localparam logic [6:0] OPC_CLKS         = 7'd8;
	// ************************************************
	// Array and dummy cycles
	// ************************************************
	localparam logic [31:0] MEM_LAST = 32'h0fff_ffff;
	localparam logic [7:0]  MEM_SEED = 8'h5a;
	localparam logic [5:0]  DUAL_DUMMY_DEF = 6'd4;
	localparam logic [5:0]  QUAD_DUMMY_DEF = 6'd8;
	localparam logic [5:0]  DUMMY_CFG1 = 6'd6;
	localparam logic [5:0]  DUMMY_CFG2 = 6'd8;
	localparam logic [5:0]  DUMMY_CFG3 = 6'd10;
	// ************************************************
	// Host register map (byte addresses)
	// ************************************************
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_ADDR   = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_DATA   = 4'hc;
	localparam int CTRL_CMD_LSB   = 0;
	localparam int CTRL_WIDE_BIT  = 4;
	localparam int CTRL_DUMMY_LSB = 8;
	localparam int CTRL_LEN_LSB   = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0001_0400;
	localparam logic [1:0] CMD_DUAL  = 2'd0;
	localparam logic [1:0] CMD_QUAD  = 2'd1;
	localparam logic [1:0] CMD_ENTER = 2'd2;
	localparam logic [1:0] CMD_EXIT  = 2'd3;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Half period of the link clock in aclk cycles
	localparam logic [2:0] SCLK_HALF = 3'd4;
endpackage : fsq_pkg

// [design/fsq_link_if.sv]
/*
 * Serial flash link between host controller and flash device.
 * Assumes a pull-up on each I/O line when neither end drives it.
 */
interface fsq_link_if;
	logic       cs_n;
	logic       sclk;
	logic [3:0] host_io_o;
	logic [3:0] host_io_oe;
	logic [3:0] dev_io_o;
	logic [3:0] dev_io_oe;
	logic [3:0] io;

	// Wire level from enables; undriven lines float high
	assign io = (dev_io_oe & dev_io_o) | (host_io_oe & ~dev_io_oe & host_io_o)
		| (~dev_io_oe & ~host_io_oe);

	modport host (output cs_n, output sclk, output host_io_o, output host_io_oe, input io);
	modport dev  (input cs_n, input sclk, output dev_io_o, output dev_io_oe, input io);
endinterface : fsq_link_if

// [design/fsq_flash_dev.sv]
/*
 * Flash device end: dual I/O read and quad output read, wide address
 * mode commands. Data comes from a fixed function of the address.
 * Assumes the host makes sclk (mode 0) and frames commands with cs_n.
 */
// Functional notes
// - Dual read: address on rise, data on fall
// - Host sends dual address on lines 1,0, releases them for dummy
// - Dual: select, opcode, 3/4 byte address
// - Dual dummy four clocks by default, then data
// - Select release ends read, stops driving
// - Address advances by one per byte
// - One command can stream whole array
// - Address wraps to zero past top
// - Three byte default, wide or extended bit
// - Dual read rejected while busy
// - Dummy count from configuration bits six, seven
// - Quad read: four bits per falling edge
// - Quad read: only data is four wide
// - Quad: serial address, eight dummy default
// - Quad data: line 3 most significant
// - Quad read rejected while busy
// - Enter/exit commands set/clear wide flag
module fsq_flash_dev (
	// Link
	fsq_link_if.dev lk,
	// Configuration and status
	input  wire logic aresetn,
	input  wire logic prog_busy,
	input  wire logic dummy_cfg_bit_low,
	input  wire logic dummy_cfg_bit_high,
	input  wire logic extended_address_bit,
	output logic      wide_addr_flag
);
	typedef enum logic [2:0] {
		FSQ_OPC   = 3'b000,
		FSQ_ADDR  = 3'b001,
		FSQ_DUMMY = 3'b011,
		FSQ_DATA  = 3'b010,
		FSQ_SKIP  = 3'b110
	} fsq_dev_st_t;

	// ************************************************
	// Helpers
	// ************************************************
	function automatic logic [7:0] mem_byte(input logic [31:0] a);
		mem_byte = a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ fsq_pkg::MEM_SEED;
	endfunction : mem_byte

	function automatic logic [3:0] slice(input logic [7:0] b, input logic [1:0] ph, input logic quad);
		logic [7:0] s;
		s = quad ? (b << {ph, 2'b00}) : (b << {ph, 1'b0});
		slice = quad ? s[7:4] : {2'b00, s[7:6]};
	endfunction : slice

	function automatic logic [5:0] dummy_of(input logic [1:0] dc, input logic quad);
		logic [5:0] d;
		d = quad ? fsq_pkg::QUAD_DUMMY_DEF : fsq_pkg::DUAL_DUMMY_DEF;
		unique case (dc)
			2'd0: dummy_of = d;
			2'd1: dummy_of = fsq_pkg::DUMMY_CFG1;
			2'd2: dummy_of = fsq_pkg::DUMMY_CFG2;
			2'd3: dummy_of = fsq_pkg::DUMMY_CFG3;
		endcase
	endfunction : dummy_of

	// ************************************************
	// Config synchronisers
	// ************************************************
	// Settings may change outside frames; two sclk edges of an
	// eight clock opcode are enough to settle them.
	logic [3:0] cfg_s1_ff;
	logic [3:0] cfg_s2_ff;

	always_ff @(posedge lk.sclk) begin
		cfg_s1_ff <= {extended_address_bit, dummy_cfg_bit_high, dummy_cfg_bit_low, prog_busy};
		cfg_s2_ff <= cfg_s1_ff;
	end

	wire       busy_s = cfg_s2_ff[0];
	wire [1:0] dc_s   = cfg_s2_ff[2:1];
	wire       ext_s  = cfg_s2_ff[3];

	// ************************************************
	// Rising edge: opcode, address, dummy
	// ************************************************
	fsq_dev_st_t st_ff;
	fsq_dev_st_t nxt_st;
	logic [5:0]  cnt_ff;
	logic [5:0]  nxt_cnt;
	logic [7:0]  opc_ff;
	logic [31:0] addr_ff;
	logic [31:0] nxt_addr;
	logic        quad_ff;
	logic        wide_ff;

	wire [7:0]  opc_in   = {opc_ff[6:0], lk.io[0]};
	wire        opc_done = (st_ff == FSQ_OPC) && (cnt_ff == 6'(fsq_pkg::OPC_CLKS - 7'd1));
	wire        is_dual  = (opc_in == fsq_pkg::OP_DUAL_IO_READ);
	wire        is_quad  = (opc_in == fsq_pkg::OP_QUAD_OUT_READ);
	wire        accept   = (is_dual || is_quad) && !busy_s;
	wire [5:0]  addr_clks = quad_ff ? (wide_ff ? 6'd32 : 6'd24) : (wide_ff ? 6'd16 : 6'd12);
	wire [5:0]  dum_clks = dummy_of(dc_s, quad_ff);
	wire        addr_end = (st_ff == FSQ_ADDR) && (cnt_ff == addr_clks - 6'd1);
	wire        dum_end  = (st_ff == FSQ_DUMMY) && (cnt_ff == dum_clks - 6'd1);
	// Dual shifts two address bits per clock, quad one
	wire [31:0] addr_in  = quad_ff ? {addr_ff[30:0], lk.io[0]} : {addr_ff[29:0], lk.io[1:0]};

	assign nxt_st = opc_done ? (accept ? FSQ_ADDR : FSQ_SKIP) :
		addr_end ? FSQ_DUMMY :
		dum_end ? FSQ_DATA : st_ff;
	assign nxt_cnt  = (nxt_st != st_ff) ? 6'd0 : 6'(cnt_ff + 6'd1);
	assign nxt_addr = (st_ff == FSQ_ADDR) ? addr_in : addr_ff;

	// Select release aborts the frame at once
	always_ff @(posedge lk.sclk or posedge lk.cs_n) begin
		if (lk.cs_n) begin
			st_ff   <= FSQ_OPC;
			cnt_ff  <= 6'd0;
			opc_ff  <= 8'h00;
			addr_ff <= 32'h0000_0000;
			quad_ff <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			cnt_ff  <= nxt_cnt;
			opc_ff  <= opc_in;
			addr_ff <= nxt_addr;
			quad_ff <= opc_done ? is_quad : quad_ff;
		end
	end

	// Wide mode survives frames; only reset or exit clears it
	always_ff @(posedge lk.sclk or negedge aresetn) begin
		if (!aresetn) begin
			wide_ff <= 1'b0;
		end else if (opc_done && (opc_in == fsq_pkg::OP_ENTER_WIDE)) begin
			wide_ff <= 1'b1;
		end else if (opc_done && (opc_in == fsq_pkg::OP_EXIT_WIDE)) begin
			wide_ff <= 1'b0;
		end
	end

	assign wide_addr_flag = wide_ff;

	// ************************************************
	// Falling edge: data launch
	// ************************************************
	logic        run_ff;
	logic [31:0] ra_ff;
	logic [1:0]  ph_ff;
	logic [3:0]  io_o_ff;
	logic [3:0]  io_oe_ff;

	// Short address takes the extended bit as bit 24
	wire [31:0] start_a = (wide_ff ? addr_ff : {7'h00, ext_s, addr_ff[23:0]}) & fsq_pkg::MEM_LAST;
	wire [31:0] cur_a   = run_ff ? ra_ff : start_a;
	wire [1:0]  cur_ph  = run_ff ? ph_ff : 2'd0;
	wire [1:0]  last_ph = quad_ff ? 2'd1 : 2'd3;
	wire        byte_end = (cur_ph == last_ph);
	wire [31:0] inc_a   = (cur_a == fsq_pkg::MEM_LAST) ? 32'h0000_0000 : 32'(cur_a + 32'd1);
	wire [3:0]  out_bits = slice(mem_byte(cur_a), cur_ph, quad_ff);
	wire [3:0]  oe_bits  = quad_ff ? 4'hf : 4'h3;

	always_ff @(negedge lk.sclk or posedge lk.cs_n) begin
		if (lk.cs_n) begin
			run_ff   <= 1'b0;
			ra_ff    <= 32'h0000_0000;
			ph_ff    <= 2'd0;
			io_o_ff  <= 4'h0;
			io_oe_ff <= 4'h0;
		end else if (st_ff == FSQ_DATA) begin
			run_ff   <= 1'b1;
			io_o_ff  <= out_bits;
			io_oe_ff <= oe_bits;
			ph_ff    <= byte_end ? 2'd0 : 2'(cur_ph + 2'd1);
			ra_ff    <= byte_end ? inc_a : cur_a;
		end else begin
			io_oe_ff <= 4'h0;
		end
	end

	assign lk.dev_io_o  = io_o_ff;
	assign lk.dev_io_oe = io_oe_ff;
endmodule : fsq_flash_dev

// [design/fsq_host_ctrl.sv]
/*
 * Host controller end: AXI4-Lite register slave that runs one flash
 * command per start and reads up to seven bytes, keeping the last four.
 * Assumes the flash end follows the same opcode and dummy settings.
 */
module fsq_host_ctrl (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Link
	fsq_link_if.host         lk
);
	typedef enum logic [1:0] {FSQ_IDLE = 2'b00, FSQ_RUN = 2'b01, FSQ_END = 2'b11} fsq_host_st_t;

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			if (s[i]) o[8*i +: 8] = n[8*i +: 8];
		end
		wmerge = o;
	endfunction : wmerge

	// ************************************************
	// Register slave
	// ************************************************
	logic [31:0] ctrl_ff, addr_ff, data_ff;
	logic [3:0]  awa_ff;
	logic [31:0] wd_ff;
	logic [3:0]  ws_ff;
	logic        done_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	fsq_host_st_t st_ff;

	wire do_wr   = !awready_ff && !wready_ff && !bvalid_ff;
	wire wr_ctrl = do_wr && (awa_ff == fsq_pkg::REG_CTRL);
	wire wr_addr = do_wr && (awa_ff == fsq_pkg::REG_ADDR);
	wire wr_stat = do_wr && (awa_ff == fsq_pkg::REG_STATUS);
	wire wr_ok   = wr_ctrl || wr_addr || wr_stat;
	// A start while a command runs is dropped
	wire go      = wr_stat && ws_ff[0] && wd_ff[0] && (st_ff == FSQ_IDLE);
	wire busy    = (st_ff != FSQ_IDLE);
	wire [31:0] stat_word = {30'h0, done_ff, busy};
	wire rd_ok   = (s_axi_araddr == fsq_pkg::REG_CTRL) || (s_axi_araddr == fsq_pkg::REG_ADDR)
		|| (s_axi_araddr == fsq_pkg::REG_STATUS) || (s_axi_araddr == fsq_pkg::REG_DATA);
	wire [31:0] rd_word = (s_axi_araddr == fsq_pkg::REG_CTRL) ? ctrl_ff :
		(s_axi_araddr == fsq_pkg::REG_ADDR) ? addr_ff :
		(s_axi_araddr == fsq_pkg::REG_STATUS) ? stat_word :
		(s_axi_araddr == fsq_pkg::REG_DATA) ? data_ff : 32'h0000_0000;
	logic fin;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= fsq_pkg::RESP_OKAY;
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rresp_ff   <= fsq_pkg::RESP_OKAY;
			rdata_ff   <= 32'h0000_0000;
			awa_ff     <= 4'h0;
			wd_ff      <= 32'h0000_0000;
			ws_ff      <= 4'h0;
			ctrl_ff    <= fsq_pkg::CTRL_RESET;
			addr_ff    <= 32'h0000_0000;
			done_ff    <= 1'b0;
		end else begin
			if (s_axi_awvalid && awready_ff) begin
				awready_ff <= 1'b0;
				awa_ff     <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_ff) begin
				wready_ff <= 1'b0;
				wd_ff     <= s_axi_wdata;
				ws_ff     <= s_axi_wstrb;
			end
			if (do_wr) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_ok ? fsq_pkg::RESP_OKAY : fsq_pkg::RESP_SLVERR;
			end
			if (s_axi_bready && bvalid_ff) begin
				bvalid_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
			if (wr_ctrl && !busy) ctrl_ff <= wmerge(ctrl_ff, wd_ff, ws_ff);
			if (wr_addr && !busy) addr_ff <= wmerge(addr_ff, wd_ff, ws_ff);
			// Completion beats a same-cycle clear
			if (fin) done_ff <= 1'b1;
			else if (wr_stat && ws_ff[0] && wd_ff[1]) done_ff <= 1'b0;
			if (s_axi_arvalid && arready_ff) begin
				arready_ff <= 1'b0;
				rvalid_ff  <= 1'b1;
				rdata_ff   <= rd_word;
				rresp_ff   <= rd_ok ? fsq_pkg::RESP_OKAY : fsq_pkg::RESP_SLVERR;
			end else if (s_axi_rready && rvalid_ff) begin
				rvalid_ff  <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end

	// ************************************************
	// Link sequencer
	// ************************************************
	wire [1:0] cmd   = ctrl_ff[fsq_pkg::CTRL_CMD_LSB +: 2];
	wire       wide  = ctrl_ff[fsq_pkg::CTRL_WIDE_BIT];
	wire [5:0] dummy = {2'b00, ctrl_ff[fsq_pkg::CTRL_DUMMY_LSB +: 4]};
	wire [2:0] len   = ctrl_ff[fsq_pkg::CTRL_LEN_LSB +: 3];
	wire       dual  = (cmd == fsq_pkg::CMD_DUAL);
	wire       rd    = (cmd == fsq_pkg::CMD_DUAL) || (cmd == fsq_pkg::CMD_QUAD);
	wire [7:0] opc   = (cmd == fsq_pkg::CMD_DUAL) ? fsq_pkg::OP_DUAL_IO_READ :
		(cmd == fsq_pkg::CMD_QUAD) ? fsq_pkg::OP_QUAD_OUT_READ :
		(cmd == fsq_pkg::CMD_ENTER) ? fsq_pkg::OP_ENTER_WIDE : fsq_pkg::OP_EXIT_WIDE;
	wire [6:0] ab    = wide ? 7'd32 : 7'd24;
	wire [6:0] a_clk = dual ? (ab >> 1) : ab;
	wire [6:0] dstart = 7'(fsq_pkg::OPC_CLKS + a_clk + {1'b0, dummy});
	wire [6:0] ncyc  = rd ? 7'(dstart + (dual ? {2'b00, len, 2'b00} : {3'b000, len, 1'b0})) : fsq_pkg::OPC_CLKS;

	logic [6:0] cyc_ff;
	logic [2:0] hc_ff;
	logic       cs_n_ff, sclk_ff;
	logic [3:0] io_o_ff, io_oe_ff, io_s1_ff, io_s2_ff;

	// Pin levels for cycle c: opcode, then address, then released
	function automatic logic [7:0] drive(input logic [6:0] c, input logic [7:0] op, input logic [31:0] a,
		input logic [6:0] ab_n, input logic dl);
		logic [6:0] k;
		k = 7'(c - fsq_pkg::OPC_CLKS);
		if (c < fsq_pkg::OPC_CLKS) drive = {4'h1, 3'b000, op[3'(7 - c[2:0])]};
		else if (!dl && k < ab_n) drive = {4'h1, 3'b000, a[5'(ab_n - 7'd1 - k)]};
		else if (dl && k < (ab_n >> 1)) drive = {4'h3, 2'b00, a[5'(ab_n - 7'd1 - {k[5:0], 1'b0})],
			a[5'(ab_n - 7'd2 - {k[5:0], 1'b0})]};
		else drive = 8'h00;
	endfunction : drive

	wire       half_end = (hc_ff == fsq_pkg::SCLK_HALF - 3'd1);
	wire       last_cyc = (cyc_ff == 7'(ncyc - 7'd1));
	wire [7:0] nxt_drv  = drive(go ? 7'd0 : 7'(cyc_ff + 7'd1), opc, addr_ff, ab, dual);
	assign fin = (st_ff == FSQ_END);

	always_ff @(posedge aclk) begin
		io_s1_ff <= lk.io;
		io_s2_ff <= io_s1_ff;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff    <= FSQ_IDLE;
			cyc_ff   <= 7'd0;
			hc_ff    <= 3'd0;
			cs_n_ff  <= 1'b1;
			sclk_ff  <= 1'b0;
			io_o_ff  <= 4'h0;
			io_oe_ff <= 4'h0;
			data_ff  <= 32'h0000_0000;
		end else begin
			unique case (st_ff)
				FSQ_IDLE: if (go) begin
					st_ff    <= FSQ_RUN;
					cs_n_ff  <= 1'b0;
					cyc_ff   <= 7'd0;
					hc_ff    <= 3'd0;
					io_oe_ff <= nxt_drv[7:4];
					io_o_ff  <= nxt_drv[3:0];
					data_ff  <= 32'h0000_0000;
				end
				FSQ_RUN: begin
					hc_ff <= half_end ? 3'd0 : 3'(hc_ff + 3'd1);
					if (half_end && !sclk_ff) begin
						sclk_ff <= 1'b1;
						if (rd && cyc_ff >= dstart)
							data_ff <= dual ? {data_ff[29:0], io_s2_ff[1:0]} : {data_ff[27:0], io_s2_ff};
					end else if (half_end) begin
						sclk_ff <= 1'b0;
						if (last_cyc) begin
							st_ff    <= FSQ_END;
							cs_n_ff  <= 1'b1;
							io_oe_ff <= 4'h0;
						end else begin
							cyc_ff   <= 7'(cyc_ff + 7'd1);
							io_oe_ff <= nxt_drv[7:4];
							io_o_ff  <= nxt_drv[3:0];
						end
					end
				end
				FSQ_END: st_ff <= FSQ_IDLE;
				default: st_ff <= FSQ_IDLE;
			endcase
		end
	end

	assign lk.cs_n       = cs_n_ff;
	assign lk.sclk       = sclk_ff;
	assign lk.host_io_o  = io_o_ff;
	assign lk.host_io_oe = io_oe_ff;
	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;
endmodule : fsq_host_ctrl

// [testbench/fsq_link_props.sv]
/*
 * Checker on the serial link that joins the host and flash ends.
 * Assumes sclk is made from aclk by the host, so aclk samples it cleanly.
 */
module fsq_link_props (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Link
	input wire logic       cs_n,
	input wire logic       sclk,
	input wire logic [3:0] host_io_o,
	input wire logic [3:0] host_io_oe,
	input wire logic [3:0] dev_io_o,
	input wire logic [3:0] dev_io_oe,
	input wire logic [3:0] io
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ************************************************
	// Rising edge count within a frame
	// ************************************************
	logic       sclk_d_ff;
	logic [6:0] rise_cnt_ff;
	wire        sclk_rise    = sclk & ~sclk_d_ff;
	wire  [6:0] nxt_rise_cnt = cs_n ? 7'd0 : rise_cnt_ff + {6'd0, sclk_rise};

	always_ff @(posedge aclk) begin
		sclk_d_ff   <= aresetn ? sclk : 1'b0;
		rise_cnt_ff <= aresetn ? nxt_rise_cnt : 7'd0;
	end

	// ************************************************
	// Properties
	// ************************************************
	sequence s_bit_held;
		(sclk && $stable(dev_io_o) && $stable(dev_io_oe))[*4];
	endsequence
	sequence s_fall;
		!sclk;
	endsequence

	property p_idle_low;
		cs_n |-> !sclk && dev_io_oe == 4'h0;
	endproperty
	property p_no_fight;
		(host_io_oe & dev_io_oe) == 4'h0;
	endproperty
	property p_quiet_head;
		!cs_n && rise_cnt_ff < 7'd24 |-> dev_io_oe == 4'h0;
	endproperty
	property p_opcode_line;
		sclk_rise && !cs_n && rise_cnt_ff < 7'd8 |-> host_io_oe == 4'h1;
	endproperty
	property p_no_high_lines;
		host_io_oe[3:2] == 2'b00;
	endproperty
	property p_oe_shape;
		dev_io_oe inside {4'h0, 4'h3, 4'hf};
	endproperty
	property p_quad_late;
		dev_io_oe == 4'hf |-> rise_cnt_ff >= 7'd38;
	endproperty
	property p_data_held;
		$rose(sclk) && !cs_n |-> s_bit_held ##1 s_fall;
	endproperty

	a_idle_low: assert property (p_idle_low) else $error("link active outside frame");
	a_no_fight: assert property (p_no_fight) else $error("both ends drive a line");
	a_quiet_head: assert property (p_quiet_head) else $error("device drives before data");
	a_opcode_line: assert property (p_opcode_line) else $error("opcode not on line 0 alone");
	a_no_high_lines: assert property (p_no_high_lines) else $error("host drives lines 3 or 2");
	a_oe_shape: assert property (p_oe_shape) else $error("device drives odd line set");
	a_quad_late: assert property (p_quad_late) else $error("quad data too early");
	a_data_held: assert property (p_data_held) else $error("data moved while clock high");
endmodule : fsq_link_props

// [testbench/tb.sv]
/*
 * Testbench: host controller and flash end joined by the link interface,
 * driven over AXI4-Lite. Assumes flash data is a fixed function of address.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        aclk, aresetn;
	logic [3:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic        prog_busy, cfg_lo, cfg_hi, ext_bit, wide_flag;
	logic [3:0]  wstrb;
	int          err_total, n_tests;

	fsq_link_if lk ();
	fsq_host_ctrl i_fsq_host_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lk(lk));
	fsq_flash_dev i_fsq_flash_dev (.lk(lk), .aresetn(aresetn), .prog_busy(prog_busy),
		.dummy_cfg_bit_low(cfg_lo), .dummy_cfg_bit_high(cfg_hi), .extended_address_bit(ext_bit),
		.wide_addr_flag(wide_flag));
	fsq_link_props i_fsq_link_props (.aclk(aclk), .aresetn(aresetn), .cs_n(lk.cs_n), .sclk(lk.sclk),
		.host_io_o(lk.host_io_o), .host_io_oe(lk.host_io_oe), .dev_io_o(lk.dev_io_o),
		.dev_io_oe(lk.dev_io_oe), .io(lk.io));

	// ************************************************
	// Bus and compare tasks
	// ************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	function automatic logic [31:0] exp_data(input logic [31:0] a, input int len);
		logic [31:0] v;
		v = 32'h0;
		for (int i = 0; i < len; i++) begin
			v = {v[23:0], a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ fsq_pkg::MEM_SEED};
			a = (a == fsq_pkg::MEM_LAST) ? 32'h0 : a + 32'h1;
		end
		return v;
	endfunction : exp_data

	// One command; read data compared only for read commands
	task automatic run(input logic [1:0] cmd, input logic wide, input logic [3:0] dmy, input logic [2:0] len,
			input logic [31:0] adr, input logic [31:0] exp);
		logic [1:0]  r;
		logic [31:0] d;
		int          k;
		axi_wr(fsq_pkg::REG_CTRL, {13'h0, len, 4'h0, dmy, 3'h0, wide, 2'h0, cmd}, r);
		chk({30'h0, r}, {30'h0, fsq_pkg::RESP_OKAY});
		axi_wr(fsq_pkg::REG_ADDR, adr, r);
		axi_wr(fsq_pkg::REG_STATUS, 32'h3, r);
		k = 0;
		d = 32'h0;
		while (d[1] !== 1'b1 && k < 400) begin
			axi_rd(fsq_pkg::REG_STATUS, d, r);
			if (k == 0) chk({31'h0, d[0]}, 32'h1);
			k++;
		end
		chk({30'h0, d[1:0]}, 32'h2);
		axi_rd(fsq_pkg::REG_DATA, d, r);
		chk({30'h0, r}, {30'h0, fsq_pkg::RESP_OKAY});
		if (cmd == fsq_pkg::CMD_DUAL || cmd == fsq_pkg::CMD_QUAD) chk(d, exp);
	endtask : run

	// ************************************************
	// Scenarios
	// ************************************************
	task automatic t_regs();
		logic [1:0]  r;
		logic [31:0] d;
		axi_rd(fsq_pkg::REG_CTRL, d, r);
		chk(d, fsq_pkg::CTRL_RESET);
		axi_wr(4'h2, 32'hffff_ffff, r);
		chk({30'h0, r}, {30'h0, fsq_pkg::RESP_SLVERR});
		axi_rd(4'h2, d, r);
		chk({30'h0, r}, {30'h0, fsq_pkg::RESP_SLVERR});
		// Only the two low byte lanes may land
		wstrb <= 4'h3;
		axi_wr(fsq_pkg::REG_ADDR, 32'haabb_ccdd, r);
		wstrb <= 4'hf;
		axi_rd(fsq_pkg::REG_ADDR, d, r);
		chk(d, 32'h0000_ccdd);
		$display("test regs done");
	endtask : t_regs

	task automatic t_reads();
		run(fsq_pkg::CMD_DUAL, 1'b0, 4'd4, 3'd4, 32'h0012_3456, exp_data(32'h0012_3456, 4));
		run(fsq_pkg::CMD_QUAD, 1'b0, 4'd8, 3'd4, 32'h00ab_cdef, exp_data(32'h00ab_cdef, 4));
		run(fsq_pkg::CMD_DUAL, 1'b0, 4'd4, 3'd1, 32'h0000_0007, exp_data(32'h0000_0007, 1));
		run(fsq_pkg::CMD_QUAD, 1'b0, 4'd8, 3'd1, 32'h00ff_ffff, exp_data(32'h00ff_ffff, 1));
		$display("test reads done");
	endtask : t_reads

	task automatic t_dummy();
		logic [5:0] tbl [4];
		tbl = '{6'd0, fsq_pkg::DUMMY_CFG1, fsq_pkg::DUMMY_CFG2, fsq_pkg::DUMMY_CFG3};
		for (int c = 1; c < 4; c++) begin
			@(posedge aclk);
			cfg_hi <= c[1];
			cfg_lo <= c[0];
			run(fsq_pkg::CMD_DUAL, 1'b0, tbl[c][3:0], 3'd2, 32'h0000_1230, exp_data(32'h0000_1230, 2));
			run(fsq_pkg::CMD_QUAD, 1'b0, tbl[c][3:0], 3'd2, 32'h0000_4560, exp_data(32'h0000_4560, 2));
		end
		@(posedge aclk);
		cfg_hi <= 1'b0;
		cfg_lo <= 1'b0;
		$display("test dummy done");
	endtask : t_dummy

	task automatic t_wide();
		@(posedge aclk);
		ext_bit <= 1'b1;
		run(fsq_pkg::CMD_DUAL, 1'b0, 4'd4, 3'd4, 32'h00ff_fffe, exp_data(32'h01ff_fffe, 4));
		@(posedge aclk);
		ext_bit <= 1'b0;
		run(fsq_pkg::CMD_ENTER, 1'b0, 4'd4, 3'd1, 32'h0, 32'h0);
		chk({31'h0, wide_flag}, 32'h1);
		run(fsq_pkg::CMD_QUAD, 1'b1, 4'd8, 3'd4, 32'h0fff_fffe, exp_data(32'h0fff_fffe, 4));
		run(fsq_pkg::CMD_DUAL, 1'b1, 4'd4, 3'd3, 32'h0fff_ffff, exp_data(32'h0fff_ffff, 3));
		run(fsq_pkg::CMD_EXIT, 1'b0, 4'd4, 3'd1, 32'h0, 32'h0);
		chk({31'h0, wide_flag}, 32'h0);
		$display("test wide done");
	endtask : t_wide

	task automatic t_busy();
		@(posedge aclk);
		prog_busy <= 1'b1;
		// Refused read: lines stay released and float high
		run(fsq_pkg::CMD_DUAL, 1'b0, 4'd4, 3'd2, 32'h0000_0100, 32'h0000_ffff);
		run(fsq_pkg::CMD_QUAD, 1'b0, 4'd8, 3'd2, 32'h0000_0100, 32'h0000_ffff);
		@(posedge aclk);
		prog_busy <= 1'b0;
		run(fsq_pkg::CMD_QUAD, 1'b0, 4'd8, 3'd2, 32'h0000_0100, exp_data(32'h0000_0100, 2));
		$display("test busy done");
	endtask : t_busy

	task automatic give_verdict();
		$display("comparisons=%0d mismatches=%0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	// ************************************************
	// Clock, reset, sequence and watchdog
	// ************************************************
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	initial begin
		// Scheduled so the flash end's async reset sees a falling edge
		aresetn <= 1'b0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{prog_busy, cfg_lo, cfg_hi, ext_bit} = '0;
		err_total = 0;
		n_tests = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_reads();
		t_dummy();
		t_wide();
		t_busy();
		give_verdict();
	end

	initial begin
		repeat (60000) @(posedge aclk);
		err_total++;
		give_verdict();
	end
endmodule : tb
